//--- hdl/intc_pkg.sv
// shared constants and types for the cascaded interrupt controller pair
package intc_pkg;
	localparam int LINES_PER_UNIT = 8;
	localparam int UNIT_COUNT = 2;
	localparam int TOTAL_LINES = 16;
	localparam int USABLE_LINES = 13;
	// lines reserved for the cascade and system use, never offered
	localparam logic [15:0] USABLE_MASK = 16'hFFE3;
	localparam logic [15:0] RESET_MASK = 16'hFFFF;
	// mask and eoi ports of both units, and their vector bases
	localparam logic [7:0] MASK_PORT_PRI = 8'h21;
	localparam logic [7:0] MASK_PORT_SEC = 8'hA1;
	localparam logic [7:0] EOI_PORT_PRI = 8'h20;
	localparam logic [7:0] EOI_PORT_SEC = 8'hA0;
	localparam logic [7:0] EOI_CMD = 8'h20;
	localparam logic [7:0] VECTOR_BASE_PRI = 8'h08;
	localparam logic [7:0] VECTOR_BASE_SEC = 8'h70;
	localparam logic [7:0] IDLE_VECTOR = 8'hFF;
	// least request spacing and the clock rate
	localparam int REQ_SPACING_NS = 125;
	localparam int CLK_PERIOD_NS = 100;
	localparam int REQ_SPACING_CYC =
		(REQ_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		HOST_IDLE = 2'b00,
		HOST_ACK  = 2'b01,
		HOST_RUN  = 2'b11,
		HOST_EOI  = 2'b10
	} host_state_t;
endpackage

//--- hdl/intc_if.sv
// link between the controller pair and the host processor
`timescale 1ns/10ps
`default_nettype none
interface intc_if;
	logic       irq;      // controller asks for service
	logic       ack;      // host takes the vector (pulse)
	logic [7:0] vector;   // winning vector, valid one cycle after irq rises
	logic       io_wr;    // host io write strobe
	logic       io_rd;    // host io read strobe
	logic [7:0] io_addr;
	logic [7:0] io_wdata;
	logic [7:0] io_rdata;
	modport ctrl (output irq, output vector, output io_rdata,
		input ack, input io_wr, input io_rd, input io_addr,
		input io_wdata);
	modport host (input irq, input vector, input io_rdata,
		output ack, output io_wr, output io_rd, output io_addr,
		output io_wdata);
endinterface
`default_nettype wire

//--- hdl/intc_ctrl.sv
// cascaded priority interrupt controller pair, device end
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - rising isa line raises interrupt if unmasked
// - vector is 8 bits naming winner
// - host fetches handler from vector table
// - host saves and restores context
// - lower line number wins priority
// - higher request preempts one in service
// - two units, thirteen usable lines
// - sources space requests 125 ns apart
// - pci lines are level sensitive
// - fixed lines serve standard resources
// - one mask bit per line, set blocks
// - mask reached through port 21h
// - host issues end of interrupt command
module intc_ctrl
	import intc_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// request lines and per-line trigger select (1 = level, pci)
	input  wire logic [15:0] irq_lines,
	input  wire logic [15:0] level_sel,
	// host side
	intc_if.ctrl             bus
);
	logic [15:0] line_q;
	logic [15:0] pend_q;
	logic [15:0] insvc_q;
	logic [15:0] mask_q;
	logic [7:0]  vector_q;
	logic [7:0]  rdata_q;
	logic [15:0] req_live;
	logic [15:0] cand;
	logic [15:0] svc_above;
	logic [4:0]  win_idx;
	logic [4:0]  top_svc;
	logic        eoi_hit;

	// previous level for edge detection
	always_ff @(posedge mclk) begin
		if (sys_rst)
			line_q <= 16'h0000;
		else
			line_q <= irq_lines;
	end

	// live request: level lines follow the pin, edge lines latch
	genvar g;
	generate
		for (g = 0; g < TOTAL_LINES; g++) begin : g_line
			assign req_live[g] = level_sel[g] ? irq_lines[g]
				: pend_q[g];
		end
	endgenerate

	// only unmasked usable lines compete
	assign cand = req_live & ~mask_q & USABLE_MASK;

	// priority: lowest number wins, and only above any in service
	always_comb begin
		win_idx = 5'd16;
		for (int i = TOTAL_LINES - 1; i >= 0; i--) begin
			if (cand[i])
				win_idx = 5'(i);
		end
		top_svc = 5'd16;
		for (int i = TOTAL_LINES - 1; i >= 0; i--) begin
			if (insvc_q[i])
				top_svc = 5'(i);
		end
		svc_above = 16'h0000;
		for (int i = 0; i < TOTAL_LINES; i++) begin
			svc_above[i] = (5'(i) < top_svc);
		end
	end

	// edge capture; a new edge wins over the ack clearing it
	always_ff @(posedge mclk) begin
		if (sys_rst)
			pend_q <= 16'h0000;
		else begin
			for (int i = 0; i < TOTAL_LINES; i++) begin
				if (!level_sel[i] && irq_lines[i] && !line_q[i])
					pend_q[i] <= 1'b1;
				else if (bus.ack && win_idx == 5'(i))
					pend_q[i] <= 1'b0;
			end
		end
	end

	assign eoi_hit = bus.io_wr && bus.io_wdata == EOI_CMD &&
		(bus.io_addr == EOI_PORT_PRI || bus.io_addr == EOI_PORT_SEC);

	// in-service bits: set on ack, highest cleared on eoi
	always_ff @(posedge mclk) begin
		if (sys_rst)
			insvc_q <= 16'h0000;
		else begin
			for (int i = 0; i < TOTAL_LINES; i++) begin
				if (bus.ack && win_idx == 5'(i))
					insvc_q[i] <= 1'b1;
				else if (eoi_hit && top_svc == 5'(i))
					insvc_q[i] <= 1'b0;
			end
		end
	end

	// mask registers: low byte primary, high byte secondary
	always_ff @(posedge mclk) begin
		if (sys_rst)
			mask_q <= RESET_MASK;
		else if (bus.io_wr && bus.io_addr == MASK_PORT_PRI)
			mask_q[7:0] <= bus.io_wdata;
		else if (bus.io_wr && bus.io_addr == MASK_PORT_SEC)
			mask_q[15:8] <= bus.io_wdata;
	end

	// read data register, unmapped ports read zero
	always_ff @(posedge mclk) begin
		if (sys_rst)
			rdata_q <= 8'h00;
		else if (bus.io_rd && bus.io_addr == MASK_PORT_PRI)
			rdata_q <= mask_q[7:0];
		else if (bus.io_rd && bus.io_addr == MASK_PORT_SEC)
			rdata_q <= mask_q[15:8];
		else if (bus.io_rd)
			rdata_q <= 8'h00;
	end

	// vector register follows the current winner
	always_ff @(posedge mclk) begin
		if (sys_rst)
			vector_q <= IDLE_VECTOR;
		else if (win_idx < 5'd8)
			vector_q <= VECTOR_BASE_PRI + {5'd0, win_idx[2:0]};
		else if (win_idx < 5'd16)
			vector_q <= VECTOR_BASE_SEC + {5'd0, win_idx[2:0]};
		else
			vector_q <= IDLE_VECTOR;
	end

	// irq is combinational so a preempting request shows at once;
	// the vector register lags one cycle, so the host waits REQ_SPACING_CYC (two) cycles
	assign bus.irq = (win_idx != 5'd16) && svc_above[win_idx[3:0]];
	assign bus.vector = vector_q;
	assign bus.io_rdata = rdata_q;
endmodule
`default_nettype wire

//--- hdl/intc_host.sv
// host processor end: takes interrupts and ends service
`timescale 1ns/10ps
`default_nettype none
module intc_host
	import intc_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// user side: service done strobe and io requests
	input  wire logic       svc_done,
	input  wire logic       user_wr,
	input  wire logic       user_rd,
	input  wire logic [7:0] user_addr,
	input  wire logic [7:0] user_wdata,
	output logic [7:0]      user_rdata,
	output logic [7:0]      taken_vector,
	output logic            in_service,
	// controller side
	intc_if.host            bus
);
	host_state_t state_q;
	logic [1:0]  wait_q;
	logic [7:0]  vec_q;

	// take, run, then send end of interrupt; wait lets vector settle
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_q <= HOST_IDLE;
			wait_q <= 2'd0;
		end else begin
			case (state_q)
				HOST_IDLE: begin
					if (bus.irq) begin
						state_q <= HOST_ACK;
						wait_q <= 2'(REQ_SPACING_CYC);
					end
				end
				HOST_ACK: begin
					if (wait_q != 2'd0)
						wait_q <= wait_q - 2'd1;
					else
						state_q <= HOST_RUN;
				end
				HOST_RUN: begin
					if (svc_done)
						state_q <= HOST_EOI;
				end
				HOST_EOI: state_q <= HOST_IDLE;
				default: state_q <= HOST_IDLE;
			endcase
		end
	end

	// vector captured at acknowledge, used to index the table
	always_ff @(posedge mclk) begin
		if (sys_rst)
			vec_q <= 8'h00;
		else if (state_q == HOST_ACK && wait_q == 2'd0)
			vec_q <= bus.vector;
	end

	assign bus.ack = (state_q == HOST_ACK) && (wait_q == 2'd0);
	assign bus.io_wr = (state_q == HOST_EOI) || user_wr;
	assign bus.io_rd = (state_q != HOST_EOI) && user_rd;
	assign bus.io_addr = (state_q == HOST_EOI) ? EOI_PORT_PRI : user_addr;
	assign bus.io_wdata = (state_q == HOST_EOI) ? EOI_CMD : user_wdata;
	assign user_rdata = bus.io_rdata;
	assign taken_vector = vec_q;
	assign in_service = (state_q == HOST_RUN);
endmodule
`default_nettype wire

//--- testbench/intc_chk.sv
// assertions on the link between controller pair and host
`timescale 1ns/10ps
`default_nettype none
module intc_chk
	import intc_pkg::*;
(
	// clock and reset
	input wire logic       mclk,
	input wire logic       sys_rst,
	// link signals
	input wire logic       irq,
	input wire logic       ack,
	input wire logic [7:0] vector,
	input wire logic       io_wr,
	input wire logic       io_rd,
	input wire logic [7:0] io_addr,
	input wire logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// reset itself is checked, so this one is never disabled
	rst_idle_a: assert property (disable iff (1'b0)
		sys_rst |=> !irq && vector == IDLE_VECTOR) else $error("not idle");
	mask_idle_a: assert property ($fell(sys_rst) |-> !irq [*2])
		else $error("irq while all masked");
	vec_range_a: assert property (irq ##1 irq |-> vector inside
		{8'h08, 8'h09, [8'h0D:8'h0F], [8'h70:8'h77]})
		else $error("bad vector");
	ack_wait_a: assert property ($rose(irq) |-> !ack ##1 !ack)
		else $error("early ack");
	ack_pulse_a: assert property (ack |=> !ack)
		else $error("ack too long");
	rd_hold_a: assert property (!io_rd |=> $stable(io_rdata))
		else $error("rdata moved");
	// excluded lines may read back as masked whatever was written
	mask_back_a: assert property (io_wr && io_addr == MASK_PORT_PRI
		##1 !io_wr ##1 io_rd && io_addr == MASK_PORT_PRI |=> (io_rdata |
		~USABLE_MASK[7:0]) == ($past(io_wdata, 3) | ~USABLE_MASK[7:0]))
		else $error("mask readback");
	unmapped_a: assert property (io_rd && !(io_addr inside
		{8'h20, 8'h21, 8'hA0, 8'hA1}) |=> io_rdata == 8'h00)
		else $error("unmapped read");
	cover property (ack);
	cover property (io_wr && io_addr == MASK_PORT_SEC);
	cover property (irq ##1 !irq);
endmodule
`default_nettype wire

//--- testbench/tb_edge_priority_interrupt_controller.sv
// self-checking bench for the cascaded interrupt controller pair
`timescale 1ns/10ps
`default_nettype none
module tb_edge_priority_interrupt_controller import intc_pkg::*;;
	logic        mclk, sys_rst, svc_done, user_wr, user_rd, in_service;
	logic [15:0] irq_lines, level_sel;
	logic [7:0]  user_addr, user_wdata, user_rdata, taken_vector, w;
	int          fails, check_count, n;
	intc_if link ();
	intc_ctrl u_intc_ctrl (.mclk, .sys_rst, .irq_lines, .level_sel,
		.bus(link.ctrl));
	intc_host u_intc_host (.mclk, .sys_rst, .svc_done, .user_wr, .user_rd,
		.user_addr, .user_wdata, .user_rdata, .taken_vector, .in_service,
		.bus(link.host));
	intc_chk u_intc_chk (.mclk, .sys_rst, .irq(link.irq), .ack(link.ack),
		.vector(link.vector), .io_wr(link.io_wr), .io_rd(link.io_rd),
		.io_addr(link.io_addr), .io_wdata(link.io_wdata),
		.io_rdata(link.io_rdata));
	// 10 MHz clock
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task tick; @(posedge mclk); #1; endtask
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [7:0] exp_vec(int k);
		return (k < 8) ? VECTOR_BASE_PRI + 8'(k) : VECTOR_BASE_SEC + 8'(k - 8);
	endfunction
	// one idle cycle between strobes, so back-to-back calls never
	// reassign a strobe in one time step; reads also wait out the
	// registered data path before sampling
	task automatic io(logic rd, logic [7:0] a, logic [7:0] d);
		user_addr = a;
		user_wdata = d;
		{user_wr, user_rd} = {~rd, rd};
		tick;
		{user_wr, user_rd} = 2'h0;
		tick;
		if (rd) repeat (2) tick;
	endtask
	task automatic wait_svc(logic v);
		for (int i = 0; i < 40 && in_service !== v; i++) tick;
		chk(8'(in_service), 8'(v));
	endtask
	task automatic done;
		svc_done = 1'b1;
		tick;
		svc_done = 1'b0;
		wait_svc(1'b0);
		repeat (2) tick;
	endtask
	// a held level line comes back after service, a held edge does not
	task automatic serve(int k, logic lvl);
		level_sel[k] = lvl;
		irq_lines[k] = 1'b1;
		wait_svc(1'b1);
		chk(taken_vector, exp_vec(k));
		done();
		chk(8'(link.irq), 8'(lvl));
		if (lvl) wait_svc(1'b1);
		irq_lines[k] = 1'b0;
		if (lvl) done();
		level_sel[k] = 1'b0;
		// let an edge pass before the next line is driven
		tick;
	endtask
	task summarize;
		$display("mismatches %0d checks %0d", fails, check_count);
		if (fails == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// watchdog well beyond the few hundred cycles of the run
	initial begin
		repeat (20000) @(posedge mclk);
		fails++;
		summarize();
	end
	// main sequence
	initial begin
		{sys_rst, svc_done, user_wr, user_rd} = 4'h8;
		{irq_lines, level_sel} = 32'h0000_0000;
		{user_addr, user_wdata} = 16'h0000;
		n = $urandom(32'h7F77);
		repeat (2) @(posedge mclk);
		#1 sys_rst = 1'b0;
		w = 8'($urandom);
		io(1'b0, MASK_PORT_PRI, w);
		io(1'b1, MASK_PORT_PRI, 8'h00);
		chk(user_rdata | ~USABLE_MASK[7:0], w | ~USABLE_MASK[7:0]);
		io(1'b1, 8'h55, 8'h00);
		chk(user_rdata, 8'h00);
		io(1'b0, MASK_PORT_PRI, 8'h00);
		io(1'b0, MASK_PORT_SEC, 8'h80);
		// line 15 stays masked, so a latched edge there never surfaces
		irq_lines = 16'h8008;
		repeat (4) tick;
		chk(8'(link.irq), 8'h00);
		irq_lines = 16'h0000;
		tick;
		for (n = 0; n < 15; n++) if (USABLE_MASK[n]) serve(n, 1'($urandom));
		irq_lines = 16'h0042;
		wait_svc(1'b1);
		chk(taken_vector, exp_vec(1));
		done();
		wait_svc(1'b1);
		chk(taken_vector, exp_vec(6));
		irq_lines = 16'h0000;
		done();
		irq_lines = 16'h0040;
		wait_svc(1'b1);
		irq_lines = 16'h00C0;
		repeat (4) tick;
		chk(8'(link.irq), 8'h00);
		irq_lines = 16'h00C1;
		repeat (2) tick;
		chk(8'(link.irq), 8'h01);
		summarize();
	end
endmodule
`default_nettype wire
